// *** logic/esl_device.sv ***
// Device end: address decode, shadow memory, freeze control and open-drain pin
// Overview of operation
// RL1 - Writing 0 drives pin low
// RL2 - Writing 1 releases pin driver
// RL3 - Pin bit reads sensed pin level
// RL4 - Pin bit is 1 after reset, sleep; here a PIO write in the same cycle as sleep_enter wins
// RL5 - Copy flag bit 7 tracks commit
// RL6 - Block writes ignored while copy busy
// RL7 - Freeze enable bit 6, next command
// RL8 - Frozen block stays write-protected forever
// RL9 - Reads unaffected by freeze state
// RL10 - Bit 1 reports parameter block frozen
// RL11 - Bit 0 reports user block frozen
// RL12 - Decode one 256-byte linear space
// RL13 - Reserved reads return undefined value
// RL14 - Host never writes reserved addresses
// RL15 - Paired values: upper byte even address
// RL16 - Upper byte read latches both bytes
// RL17 - Host reads both bytes per command; here each read command returns one byte, so the host issues two reads
// RL18 - Reads, writes reach shadow copy only
// RL19 - Commit to cells, reload to shadow
// RL20 - Host writes then commits, reloads then reads
// RL21 - Sixteen user bytes at 20h-2Fh
// RL22 - Control shadow reloaded at power-up
// RL23 - Freeze names one block only
`timescale 1ns/1ps
module esl_device
   import esl_pkg::*;
#(
   parameter int COPY_CYC = ESL_COPY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   esl_if.dev link,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   input wire logic sleep_enter,
   input wire logic [15:0] pair_value [14],
   output logic [7:0] control_value
);
   logic pin_meta_reg, pin_sync_reg;
   logic pin_bit_reg, pin_bit_next;
   logic frz_en_reg, frz_en_next;
   logic ufrz_reg = 1'b0;
   logic ufrz_next;
   logic pfrz_reg = 1'b0;
   logic pfrz_next;
   logic [7:0] latch_lsb_reg, latch_lsb_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rsp_reg, rsp_next;
   logic pin_out_reg, pin_out_next;
   logic pin_oe_reg, pin_oe_next;
   logic [7:0] ctrl_out_reg, ctrl_out_next;
   logic in_b0, in_b1, in_blk, take, is_wr, wr_ok, copy_go, recall_go;
   logic [4:0] blk_idx;
   logic [7:0] nvm_rd, ctrl_sh, nvc_val;
   logic copy_busy;
   logic [3:0] pair_idx;

   esl_nvm_block #(.COPY_CYC(COPY_CYC)) u_nvm (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_ok),
      .wr_idx(blk_idx),
      .wr_blk(in_b1),
      .wr_data(link.cmd_wdata),
      .rd_idx(blk_idx),
      .rd_blk(in_b1),
      .rd_data(nvm_rd),
      .copy_go(copy_go),
      .recall_go(recall_go),
      .sel_blk(link.cmd_blk),
      .copy_busy(copy_busy),
      .ctrl_shadow(ctrl_sh)
   );

   // Pin level comes from outside, so it is synchronised first
   always_ff @(posedge clock) begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
   end

   assign in_b0 = link.cmd_addr >= ESL_BLK0_LO && link.cmd_addr <= ESL_BLK0_HI; // RL12 RL21
   assign in_b1 = link.cmd_addr >= ESL_BLK1_LO && link.cmd_addr <= ESL_BLK1_HI; // RL12
   assign in_blk = in_b0 || in_b1;
   assign blk_idx = in_b1 ? 5'(link.cmd_addr - ESL_BLK1_LO) : 5'(link.cmd_addr - ESL_BLK0_LO);
   // The host sends at most one command per cycle, so a command is taken on sight
   assign take = link.cmd_valid;
   assign is_wr = take && link.cmd_op == ESL_CMD_WRITE;
   // Refused block writes are dropped, not held back until the commit ends
   assign wr_ok = is_wr && in_blk && !copy_busy
      && !(in_b0 && ufrz_reg) && !(in_b1 && pfrz_reg); // RL6 RL8 RL23
   assign copy_go = take && link.cmd_op == ESL_CMD_COPY && !copy_busy; // RL19
   assign recall_go = take && link.cmd_op == ESL_CMD_RECALL && !copy_busy; // RL19
   assign pair_idx = 4'((link.cmd_addr - ESL_PAIR_LO) >> 1);

   always_comb begin
      // Unused bits read as the reserved value
      nvc_val = ESL_RSVD_VAL;
      nvc_val[ESL_BIT_COPY] = copy_busy; // RL5
      nvc_val[ESL_BIT_FRZEN] = frz_en_reg; // RL7
      nvc_val[ESL_BIT_PFRZ] = pfrz_reg; // RL10
      nvc_val[ESL_BIT_UFRZ] = ufrz_reg; // RL11
   end

   always_comb begin
      pin_bit_next = pin_bit_reg;
      frz_en_next = frz_en_reg;
      ufrz_next = ufrz_reg;
      pfrz_next = pfrz_reg;
      latch_lsb_next = latch_lsb_reg;
      rdata_next = rdata_reg;
      rsp_next = 1'b0;
      if (sleep_enter) begin
         pin_bit_next = 1'b1; // RL4
      end
      if (take) begin
         // Any command other than the freeze drops the enable, except a write to ESL_ADDR_NVC, which loads it from bit 6
         if (link.cmd_op != ESL_CMD_LOCK) begin
            frz_en_next = 1'b0; // RL7
         end
         unique case (link.cmd_op)
            ESL_CMD_WRITE: begin
               if (link.cmd_addr == ESL_ADDR_PIO) begin
                  pin_bit_next = link.cmd_wdata[ESL_BIT_PIN]; // RL1 RL2
               end else if (link.cmd_addr == ESL_ADDR_NVC) begin
                  frz_en_next = link.cmd_wdata[ESL_BIT_FRZEN]; // RL7
               end
            end
            ESL_CMD_LOCK: begin
               if (frz_en_reg) begin
                  if (link.cmd_blk) begin
                     pfrz_next = 1'b1; // RL8 RL23
                  end else begin
                     ufrz_next = 1'b1; // RL8 RL23
                  end
               end
               frz_en_next = 1'b0; // RL7
            end
            ESL_CMD_READ: begin
               rsp_next = 1'b1;
               rdata_next = ESL_RSVD_VAL; // RL13
               if (in_blk) begin
                  rdata_next = nvm_rd; // RL9 RL18
               end else if (link.cmd_addr == ESL_ADDR_PIO) begin
                  rdata_next = {7'h00, pin_sync_reg}; // RL3
               end else if (link.cmd_addr == ESL_ADDR_NVC) begin
                  rdata_next = nvc_val;
               end else if (link.cmd_addr >= ESL_PAIR_LO && link.cmd_addr <= ESL_PAIR_HI) begin
                  // The low byte stays latched until the next upper-byte read
                  if (!link.cmd_addr[0]) begin
                     rdata_next = pair_value[pair_idx][15:8]; // RL15
                     latch_lsb_next = pair_value[pair_idx][7:0]; // RL16
                  end else begin
                     rdata_next = latch_lsb_reg; // RL16
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Output registers: the top-level pins come straight from flops
   always_comb begin
      pin_out_next = 1'b0; // RL1
      pin_oe_next = !pin_bit_next; // RL1 RL2
      ctrl_out_next = ctrl_sh; // RL22
   end

   // Frozen flags and cells are kept apart from this reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_bit_reg <= 1'b1; // RL4
         frz_en_reg <= 1'b0; // RL7
         latch_lsb_reg <= 8'h00;
         rdata_reg <= 8'h00;
         rsp_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0; // RL4
         ctrl_out_reg <= 8'h00;
      end else begin
         pin_bit_reg <= pin_bit_next;
         frz_en_reg <= frz_en_next;
         latch_lsb_reg <= latch_lsb_next;
         rdata_reg <= rdata_next;
         rsp_reg <= rsp_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         ctrl_out_reg <= ctrl_out_next;
      end
   end

   // Frozen flags model one-time cells: reset leaves them alone, so a lock
   // outlives a power cycle; the start value stands for the factory state
   always_ff @(posedge clock) begin
      ufrz_reg <= ufrz_next; // RL8
      pfrz_reg <= pfrz_next; // RL8
   end

   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign control_value = ctrl_out_reg;
   assign link.rsp_valid = rsp_reg;
   assign link.rsp_rdata = rdata_reg;
   // Busy is the engine's own flop, so it spans exactly the commit
   assign link.busy = copy_busy; // RL5
endmodule : esl_device

// *** logic/esl_pkg.sv ***
// Package: memory map, field positions and command codes for the shadow memory block
package esl_pkg;
   localparam int ESL_AW = 8;
   localparam int ESL_DW = 8;
   localparam logic [7:0] ESL_ADDR_PIO = 8'h15;
   localparam logic [7:0] ESL_ADDR_NVC = 8'h1f;
   localparam logic [7:0] ESL_BLK0_LO = 8'h20;
   localparam logic [7:0] ESL_BLK0_HI = 8'h2f;
   localparam logic [7:0] ESL_BLK1_LO = 8'h60;
   localparam logic [7:0] ESL_BLK1_HI = 8'h7f;
   localparam logic [7:0] ESL_ADDR_CTRL = 8'h60;
   localparam logic [7:0] ESL_PAIR_LO = 8'h02;
   localparam logic [7:0] ESL_PAIR_HI = 8'h1b;
   localparam int ESL_BIT_PIN = 0;
   localparam int ESL_BIT_COPY = 7;
   localparam int ESL_BIT_FRZEN = 6;
   localparam int ESL_BIT_PFRZ = 1;
   localparam int ESL_BIT_UFRZ = 0;
   localparam logic [7:0] ESL_RSVD_VAL = 8'h00;
   localparam int ESL_COPY_CYC = 16;
   typedef enum logic [2:0] {
      ESL_CMD_READ = 3'h0,
      ESL_CMD_WRITE = 3'h1,
      ESL_CMD_COPY = 3'h2,
      ESL_CMD_RECALL = 3'h3,
      ESL_CMD_LOCK = 3'h4,
      ESL_CMD_END = 3'h5
   } esl_cmd_e;
endpackage : esl_pkg

// *** logic/esl_if.sv ***
// Interface: command link between host master and shadow memory device
`timescale 1ns/1ps
interface esl_if;
   logic cmd_valid;
   logic [2:0] cmd_op;
   logic [7:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic cmd_blk;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic busy;
   modport dev (input cmd_valid, input cmd_op, input cmd_addr, input cmd_wdata, input cmd_blk,
      output rsp_valid, output rsp_rdata, output busy);
   modport host (output cmd_valid, output cmd_op, output cmd_addr, output cmd_wdata,
      output cmd_blk, input rsp_valid, input rsp_rdata, input busy);
endinterface : esl_if

// *** logic/esl_nvm_block.sv ***
// Nonvolatile cell array with shadow copy, commit and reload engine
`timescale 1ns/1ps
module esl_nvm_block
   import esl_pkg::*;
#(
   parameter int COPY_CYC = ESL_COPY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [4:0] wr_idx,
   input wire logic wr_blk,
   input wire logic [7:0] wr_data,
   input wire logic [4:0] rd_idx,
   input wire logic rd_blk,
   output logic [7:0] rd_data,
   input wire logic copy_go,
   input wire logic recall_go,
   input wire logic sel_blk,
   output logic copy_busy,
   output logic [7:0] ctrl_shadow
);
   logic [7:0] shadow0_reg [16];
   logic [7:0] shadow1_reg [32];
   logic [7:0] cell0_reg [16];
   logic [7:0] cell1_reg [32];
   logic [7:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic blk_reg, blk_next;
   logic boot_reg;
   localparam logic [7:0] CNT_END = 8'(COPY_CYC - 1);

   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      blk_next = blk_reg;
      if (busy_reg) begin
         cnt_next = cnt_reg + 8'h01;
         if (cnt_reg == CNT_END) begin
            busy_next = 1'b0;
         end
      end else if (copy_go) begin
         busy_next = 1'b1;
         cnt_next = 8'h00;
         blk_next = sel_blk;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         busy_reg <= 1'b0;
         blk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         blk_reg <= blk_next;
      end
   end

   // Cells keep their contents across reset; shadow is reloaded from them after reset
   always_ff @(posedge clock) begin
      boot_reg <= !rst_n;
      for (int i = 0; i < 32; i++) begin
         if ((boot_reg || (recall_go && sel_blk)) && rst_n) begin
            shadow1_reg[i] <= cell1_reg[i]; // RL19 RL22
         end else if (wr_en && wr_blk && wr_idx == 5'(i)) begin
            shadow1_reg[i] <= wr_data; // RL18
         end
         if (busy_reg && blk_reg && cnt_reg == CNT_END) begin
            cell1_reg[i] <= shadow1_reg[i]; // RL19
         end
      end
      for (int i = 0; i < 16; i++) begin
         if ((boot_reg || (recall_go && !sel_blk)) && rst_n) begin
            shadow0_reg[i] <= cell0_reg[i]; // RL19
         end else if (wr_en && !wr_blk && wr_idx == 5'(i)) begin
            shadow0_reg[i] <= wr_data; // RL18 RL21
         end
         if (busy_reg && !blk_reg && cnt_reg == CNT_END) begin
            cell0_reg[i] <= shadow0_reg[i]; // RL19
         end
      end
   end

   assign rd_data = rd_blk ? shadow1_reg[rd_idx] : shadow0_reg[rd_idx[3:0]]; // RL9 RL18
   assign copy_busy = busy_reg;
   assign ctrl_shadow = shadow1_reg[0];
endmodule : esl_nvm_block

// *** logic/esl_host.sv ***
// Host end: turns user requests into link commands and returns read data
`timescale 1ns/1ps
module esl_host
   import esl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   esl_if.host link,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic req_blk,
   output logic req_ready,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   logic vld_reg, vld_next;
   logic [2:0] op_reg, op_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] wd_reg, wd_next;
   logic blk_reg, blk_next;
   logic rv_reg, rv_next;
   logic [7:0] rd_reg, rd_next;
   logic rdy_reg, rdy_next;

   // One command per cycle; a refused request waits while the device is busy
   always_comb begin
      vld_next = 1'b0;
      op_next = op_reg;
      addr_next = addr_reg;
      wd_next = wd_reg;
      blk_next = blk_reg;
      rv_next = link.rsp_valid;
      rd_next = link.rsp_valid ? link.rsp_rdata : rd_reg;
      rdy_next = !link.busy;
      if (req_valid && rdy_reg && !link.busy) begin
         vld_next = 1'b1; // RL14 RL17 RL20
         op_next = req_op;
         addr_next = req_addr;
         wd_next = req_wdata;
         blk_next = req_blk;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vld_reg <= 1'b0;
         op_reg <= 3'h0;
         addr_reg <= 8'h00;
         wd_reg <= 8'h00;
         blk_reg <= 1'b0;
         rv_reg <= 1'b0;
         rd_reg <= 8'h00;
         rdy_reg <= 1'b0;
      end else begin
         vld_reg <= vld_next;
         op_reg <= op_next;
         addr_reg <= addr_next;
         wd_reg <= wd_next;
         blk_reg <= blk_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rdy_reg <= rdy_next;
      end
   end

   assign link.cmd_valid = vld_reg;
   assign link.cmd_op = op_reg;
   assign link.cmd_addr = addr_reg;
   assign link.cmd_wdata = wd_reg;
   assign link.cmd_blk = blk_reg;
   assign req_ready = rdy_reg;
   assign rd_valid = rv_reg;
   assign rd_data = rd_reg;
endmodule : esl_host

// *** verif/esl_properties.sv ***
// Checker for the command link between host and device ends
`timescale 1ns/1ps
module esl_properties
   import esl_pkg::*;
#(
   parameter int COPY_CYC = ESL_COPY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_blk,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_rdata,
   input wire logic busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [7:0] bcnt_reg, bcnt_next;
   logic [1:0] frz_reg, frz_next;
   logic nvc_reg, nvc_next;
   // Frozen flags seen once must be seen again; knowledge restarts at reset
   always_comb begin
      bcnt_next = busy ? bcnt_reg + 8'h01 : 8'h00;
      nvc_next = cmd_valid && cmd_op == ESL_CMD_READ && cmd_addr == ESL_ADDR_NVC;
      frz_next = frz_reg | ((rsp_valid && nvc_reg) ? rsp_rdata[1:0] : 2'h0);
      if (!rst_n) begin
         bcnt_next = 8'h00;
         nvc_next = 1'b0;
         frz_next = 2'h0;
      end
   end
   always_ff @(posedge clock) begin
      bcnt_reg <= bcnt_next;
      nvc_reg <= nvc_next;
      frz_reg <= frz_next;
   end
   sequence s_rd;
      cmd_valid && cmd_op == ESL_CMD_READ;
   endsequence
   sequence s_copy;
      cmd_valid && cmd_op == ESL_CMD_COPY && !busy;
   endsequence
   a_rsp_after_read: assert property (s_rd |=> rsp_valid)
      else $error("no response after read");
   a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid) && $past(cmd_op) == 3'h0)
      else $error("response without read");
   a_copy_sets_busy: assert property (s_copy |=> busy)
      else $error("commit did not raise busy");
   a_busy_has_cause: assert property ($rose(busy) |-> $past(cmd_valid) && $past(cmd_op) == 3'h2)
      else $error("busy without commit");
   a_busy_length: assert property ($fell(busy) |-> bcnt_reg == 8'(COPY_CYC))
      else $error("commit length wrong");
   a_busy_bound: assert property (busy |-> bcnt_reg < 8'(COPY_CYC))
      else $error("commit overran");
   a_copy_flag_read: assert property (rsp_valid && nvc_reg |-> rsp_rdata[7] == $past(busy))
      else $error("copy flag differs from busy");
   a_reserved_zero: assert property (s_rd ##0 cmd_addr[7] |=> rsp_rdata == ESL_RSVD_VAL)
      else $error("reserved read not zero");
   a_frozen_sticky: assert property (rsp_valid && nvc_reg |-> (rsp_rdata[1:0] & frz_reg) == frz_reg)
      else $error("frozen flag cleared");
endmodule : esl_properties

// *** verif/tb_eeprom_shadow_lock_and_pio.sv ***
// Testbench: host and device ends joined by the command link
`timescale 1ns/1ps
module tb_eeprom_shadow_lock_and_pio
   import esl_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [7:0] req_addr = 8'h00;
   logic [7:0] req_wdata = 8'h00;
   logic req_blk = 1'b0;
   logic sleep_enter = 1'b0;
   logic ext_lvl = 1'b1;
   logic req_ready, rd_valid, pin_out, pin_oe, pin_in;
   logic [7:0] rd_data, control_value, got;
   logic [15:0] pair_value [14];
   int failures = 0;
   int n_compared = 0;
   esl_if link();
   // Open drain: released pin follows the outside level
   assign pin_in = pin_oe ? pin_out : ext_lvl;
   always #5 clock = ~clock;
   esl_host i_esl_host (.clock(clock), .rst_n(rst_n), .link(link), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_blk(req_blk),
      .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
   esl_device #(.COPY_CYC(2)) i_esl_device (.clock(clock), .rst_n(rst_n), .link(link),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .sleep_enter(sleep_enter),
      .pair_value(pair_value), .control_value(control_value));
   esl_properties #(.COPY_CYC(2)) i_esl_properties (.clock(clock), .rst_n(rst_n),
      .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr),
      .cmd_wdata(link.cmd_wdata), .cmd_blk(link.cmd_blk), .rsp_valid(link.rsp_valid),
      .rsp_rdata(link.rsp_rdata), .busy(link.busy));
   task automatic stop_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Waits a falling edge first so valid is never lowered and raised in one step
   task automatic cmd(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
      input logic b);
      int n;
      n = 0;
      @(negedge clock);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      req_blk = b;
      while (!(req_ready === 1'b1 && link.busy === 1'b0) && n < 50) begin
         @(negedge clock);
         n++;
      end
      if (n == 50) failures++;
      @(negedge clock);
      req_valid = 1'b0;
   endtask : cmd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cmd(ESL_CMD_WRITE, a, d, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      cmd(ESL_CMD_READ, a, 8'h00, 1'b0);
      while (rd_valid !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      if (n == 20) failures++;
      got = rd_data;
   endtask : rd
   task automatic copy(input logic b);
      int n;
      n = 0;
      cmd(ESL_CMD_COPY, 8'h00, 8'h00, b);
      repeat (5) begin
         @(negedge clock);
         if (link.busy === 1'b1) n++;
      end
      check("busy_len", 8'(n), 8'h02);
   endtask : copy
   // Pin write, then time for the two-flop sense path to settle
   task automatic pin_wr(input logic d);
      wr(ESL_ADDR_PIO, {7'h00, d});
      repeat (4) @(negedge clock);
      check("pin_oe", {7'h00, pin_oe}, {7'h00, ~d});
      check("pin_out", {7'h00, pin_out}, 8'h00);
   endtask : pin_wr
   initial begin
      #200000;
      failures++;
      stop_test();
   end
   initial begin
      for (int i = 0; i < 14; i++) pair_value[i] = 16'h0000;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (2) @(negedge clock);
      check("oe_rst", {7'h00, pin_oe}, 8'h00);
      rd(ESL_ADDR_NVC);
      check("nvc_rst", got & 8'hc3, 8'h00);
      rd(ESL_ADDR_PIO);
      check("pin_hi", got & 8'h01, 8'h01);
      pin_wr(1'b0);
      rd(ESL_ADDR_PIO);
      check("pin_lo", got & 8'h01, 8'h00);
      pin_wr(1'b1);
      rd(ESL_ADDR_PIO);
      check("pin_rel", got & 8'h01, 8'h01);
      ext_lvl = 1'b0;
      pin_wr(1'b1);
      rd(ESL_ADDR_PIO);
      check("pin_pd", got & 8'h01, 8'h00);
      ext_lvl = 1'b1;
      pin_wr(1'b0);
      sleep_enter = 1'b1;
      @(negedge clock);
      sleep_enter = 1'b0;
      repeat (2) @(negedge clock);
      check("oe_sleep", {7'h00, pin_oe}, 8'h00);
      wr(8'h20, 8'ha5);
      wr(8'h2f, 8'h5a);
      rd(8'h20);
      check("u20", got, 8'ha5);
      rd(8'h2f);
      check("u2f", got, 8'h5a);
      copy(1'b0);
      rd(ESL_ADDR_NVC);
      check("eec_done", got & 8'h80, 8'h00);
      wr(8'h20, 8'h00);
      rd(8'h20);
      check("u20_sh", got, 8'h00);
      cmd(ESL_CMD_RECALL, 8'h00, 8'h00, 1'b0);
      rd(8'h20);
      check("u20_rc", got, 8'ha5);
      wr(ESL_ADDR_CTRL, 8'h3c);
      copy(1'b1);
      wr(ESL_ADDR_CTRL, 8'h11);
      rst_n = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (2) @(negedge clock);
      check("ctrl_pu", control_value, 8'h3c);
      wr(ESL_ADDR_NVC, 8'h40);
      cmd(ESL_CMD_LOCK, 8'h00, 8'h00, 1'b0);
      rd(ESL_ADDR_NVC);
      check("lock0", got & 8'hc3, 8'h01);
      wr(8'h20, 8'hff);
      rd(8'h20);
      check("u20_frz", got, 8'ha5);
      wr(ESL_ADDR_CTRL, 8'h77);
      rd(ESL_ADDR_CTRL);
      check("ctrl_wr", got, 8'h77);
      wr(ESL_ADDR_NVC, 8'h40);
      rd(ESL_ADDR_PIO);
      cmd(ESL_CMD_LOCK, 8'h00, 8'h00, 1'b1);
      rd(ESL_ADDR_NVC);
      check("lock_late", got & 8'hc3, 8'h01);
      wr(ESL_ADDR_NVC, 8'h00);
      rd(ESL_ADDR_NVC);
      check("no_unlock", got & 8'h03, 8'h01);
      wr(ESL_ADDR_NVC, 8'h40);
      cmd(ESL_CMD_LOCK, 8'h00, 8'h00, 1'b1);
      rd(ESL_ADDR_NVC);
      check("lock1", got & 8'hc3, 8'h03);
      wr(ESL_ADDR_CTRL, 8'h00);
      rd(ESL_ADDR_CTRL);
      check("ctrl_frz", got, 8'h77);
      rd(8'h80);
      check("rsv80", got, ESL_RSVD_VAL);
      rd(8'h1c);
      check("rsv1c", got, ESL_RSVD_VAL);
      pair_value[0] = 16'h1234;
      rd(8'h02);
      check("msb", got, 8'h12);
      pair_value[0] = 16'h5678;
      rd(8'h03);
      check("lsb_held", got, 8'h34);
      cmd(ESL_CMD_END, 8'h00, 8'h00, 1'b0);
      pair_value[12] = 16'hbeef;
      rd(8'h1a);
      check("msb_1a", got, 8'hbe);
      rd(8'h1b);
      check("lsb_1b", got, 8'hef);
      stop_test();
   end
endmodule : tb_eeprom_shadow_lock_and_pio
